// ==== rtl/pbc_cfg.svh ====
// Purpose: Offsets, field positions, reset values for the pin-change block
// Assumes: Byte addresses on a 32-bit AXI4-Lite bus
// Notes: Definitions only
`ifndef PBC_CFG_SVH
`define PBC_CFG_SVH

`define PBC_OFF_FLAGS 8'h00
`define PBC_OFF_RISE 8'h04
`define PBC_OFF_FALL 8'h08
`define PBC_OFF_ICTL 8'h0c
`define PBC_OFF_STAT 8'h10
`define PBC_OFF_MASK 8'h14

`define PBC_PIN_LSB 4
`define PBC_PIN_MSB 7
`define PBC_ICTL_FLAG_BIT 0
`define PBC_ICTL_IE_BIT 3

`define PBC_RST_PINS 4'h0
`define PBC_RST_BIT 1'b0
`define PBC_RST_WARM 2'h0

`define PBC_RESP_OKAY 2'h0
`define PBC_RESP_SLVERR 2'h2

`define PBC_SYNC_STAGES 2

`endif

// ==== rtl/pbc_pkg.sv ====
// Purpose: Types shared by the pin-change block
// Assumes: Four port pins, bits 7 to 4 of each pin register; the interrupt control register uses bits 3 and 0
// Notes: Constants live in pbc_cfg.svh
package pbc_pkg;

    typedef enum logic [2:0]
    {
        PBC_SEL_NONE,
        PBC_SEL_FLAGS,
        PBC_SEL_RISE,
        PBC_SEL_FALL,
        PBC_SEL_ICTL,
        PBC_SEL_STAT,
        PBC_SEL_MASK
    } pbc_sel_type;

    typedef struct packed
    {
        logic [3:0] flags;
        logic [3:0] rise_en;
        logic [3:0] fall_en;
        logic irq_en;
        logic [3:0] status;
        logic [3:0] mask;
    } pbc_regs_type;

    typedef struct packed
    {
        logic [3:0] stage1;
        logic [3:0] stage2;
        logic [3:0] prev;
        logic [1:0] warm;
        logic primed;
    } pbc_sync_type;

    typedef struct packed
    {
        logic aw_got;
        logic w_got;
        logic [7:0] addr;
        logic [7:0] data;
        logic strb0;
        logic bvalid;
        logic [1:0] bresp;
    } pbc_wr_type;

    typedef struct packed
    {
        logic rvalid;
        logic [7:0] data;
        logic [1:0] rresp;
    } pbc_rd_type;

endpackage : pbc_pkg

// ==== rtl/pbc_top.sv ====
// Purpose: Port B pin-change edge detect, sticky flags and interrupt
// Assumes: Pins are asynchronous; one clock aclk; AXI4-Lite register access
// Notes: Only pins 7 to 4 exist; lower bits of the pin registers read as zero
// Operation
// - Rising edge on pin 7..4 with its rise enable set sets its change flag.
// - Falling edge on a pin with its fall enable set sets its change flag.
// - A change flag stays set until software writes zero to it.
// - Bits 3 to 0 of the change-flag register always read zero.
// - Rise enable one arms rising detection; zero disables it for that pin.
// - Fall enable one arms falling detection; zero disables it for that pin.
//
// The implementer's own choices: the AXI4-Lite slave port and the register offsets.
`timescale 1ns/1ps
`include "pbc_cfg.svh"

module pbc_top
(
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Port B pins 7..4
    input wire logic [3:0] portb_pin_x,
    // AXI4-Lite write address
    input wire logic [7:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    // Interrupt
    output logic global_change_flag,
    output logic irq
);
    import pbc_pkg::*;

    function automatic pbc_sel_type pbc_decode(input logic [7:0] addr);
        pbc_sel_type sel;
        sel = PBC_SEL_NONE;
        unique case (addr)
            `PBC_OFF_FLAGS: sel = PBC_SEL_FLAGS;
            `PBC_OFF_RISE: sel = PBC_SEL_RISE;
            `PBC_OFF_FALL: sel = PBC_SEL_FALL;
            `PBC_OFF_ICTL: sel = PBC_SEL_ICTL;
            `PBC_OFF_STAT: sel = PBC_SEL_STAT;
            `PBC_OFF_MASK: sel = PBC_SEL_MASK;
            default: sel = PBC_SEL_NONE;
        endcase
        return sel;
    endfunction : pbc_decode

    pbc_sync_type sync_reg;
    pbc_sync_type sync_next;
    pbc_regs_type regs_reg;
    pbc_regs_type regs_next;
    pbc_wr_type wr_reg;
    pbc_wr_type wr_next;
    pbc_rd_type rd_reg;
    pbc_rd_type rd_next;

    logic [3:0] rise_hit;
    logic [3:0] fall_hit;
    logic [3:0] edge_set;
    logic do_write;
    pbc_sel_type wr_sel;
    pbc_sel_type rd_sel;
    logic ar_take;
    logic aw_take;
    logic w_take;
    logic [7:0] rd_value;
    logic irq_from_flags;
    logic irq_from_status;

    // Pin synchroniser and edge history
    always_comb
    begin
        sync_next = sync_reg;
        sync_next.stage1 = portb_pin_x;
        sync_next.stage2 = sync_reg.stage1;
        sync_next.prev = sync_reg.stage2;
        // History is valid three edges after reset, once stage2 and prev hold pin levels
        sync_next.warm = {sync_reg.warm[0], 1'b1};
        // Avoid a false edge from the reset value of the history
        sync_next.primed = sync_reg.warm[1];
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sync_reg.stage1 <= `PBC_RST_PINS;
            sync_reg.stage2 <= `PBC_RST_PINS;
            sync_reg.prev <= `PBC_RST_PINS;
            sync_reg.warm <= `PBC_RST_WARM;
            sync_reg.primed <= `PBC_RST_BIT;
        end
        else if (ce)
        begin
            sync_reg <= sync_next;
        end
    end

    // Qualified edges, one per pin
    genvar gi;
    generate
        for (gi = 0; gi < 4; gi++)
        begin : g_edge
            assign rise_hit[gi] = sync_reg.primed && regs_reg.rise_en[gi]
                && sync_reg.stage2[gi] && !sync_reg.prev[gi];
            assign fall_hit[gi] = sync_reg.primed && regs_reg.fall_en[gi]
                && !sync_reg.stage2[gi] && sync_reg.prev[gi];
        end
    endgenerate

    assign edge_set = rise_hit | fall_hit;

    // Write channel handshakes
    // Address and data may arrive in either order
    assign s_axi_awready = ce && !wr_reg.aw_got && !wr_reg.bvalid;
    assign s_axi_wready = ce && !wr_reg.w_got && !wr_reg.bvalid;
    assign aw_take = s_axi_awvalid && s_axi_awready;
    assign w_take = s_axi_wvalid && s_axi_wready;
    assign do_write = wr_reg.aw_got && wr_reg.w_got;
    assign wr_sel = pbc_decode(wr_reg.addr);

    always_comb
    begin
        wr_next = wr_reg;
        if (aw_take)
        begin
            wr_next.aw_got = 1'b1;
            wr_next.addr = s_axi_awaddr;
        end
        if (w_take)
        begin
            wr_next.w_got = 1'b1;
            wr_next.data = s_axi_wdata[7:0];
            wr_next.strb0 = s_axi_wstrb[0];
        end
        // Write lands one edge after the later of address and data
        if (do_write)
        begin
            wr_next.aw_got = 1'b0;
            wr_next.w_got = 1'b0;
            wr_next.bvalid = 1'b1;
            wr_next.bresp = (wr_sel == PBC_SEL_NONE) ? `PBC_RESP_SLVERR : `PBC_RESP_OKAY;
        end
        else if (wr_reg.bvalid && s_axi_bready)
        begin
            wr_next.bvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            wr_reg.aw_got <= `PBC_RST_BIT;
            wr_reg.w_got <= `PBC_RST_BIT;
            wr_reg.addr <= 8'h00;
            wr_reg.data <= 8'h00;
            wr_reg.strb0 <= `PBC_RST_BIT;
            wr_reg.bvalid <= `PBC_RST_BIT;
            wr_reg.bresp <= `PBC_RESP_OKAY;
        end
        else if (ce)
        begin
            wr_reg <= wr_next;
        end
    end

    assign s_axi_bvalid = wr_reg.bvalid;
    assign s_axi_bresp = wr_reg.bresp;

    // Read channel
    // Read data is captured at the edge that takes the address
    assign s_axi_arready = ce && !rd_reg.rvalid;
    assign ar_take = s_axi_arvalid && s_axi_arready;
    assign rd_sel = pbc_decode(s_axi_araddr);

    always_comb
    begin
        rd_value = 8'h00;
        unique case (rd_sel)
            // Low nibble is unimplemented and reads zero
            PBC_SEL_FLAGS: rd_value = {regs_reg.flags, 4'h0};
            PBC_SEL_RISE: rd_value = {regs_reg.rise_en, 4'h0};
            PBC_SEL_FALL: rd_value = {regs_reg.fall_en, 4'h0};
            PBC_SEL_ICTL:
            begin
                // Only the enable and the global flag exist here
                rd_value[`PBC_ICTL_IE_BIT] = regs_reg.irq_en;
                rd_value[`PBC_ICTL_FLAG_BIT] = global_change_flag;
            end
            PBC_SEL_STAT: rd_value = {regs_reg.status, 4'h0};
            PBC_SEL_MASK: rd_value = {regs_reg.mask, 4'h0};
            PBC_SEL_NONE: rd_value = 8'h00;
        endcase
    end

    always_comb
    begin
        rd_next = rd_reg;
        if (ar_take)
        begin
            rd_next.rvalid = 1'b1;
            rd_next.data = rd_value;
            rd_next.rresp = (rd_sel == PBC_SEL_NONE) ? `PBC_RESP_SLVERR : `PBC_RESP_OKAY;
        end
        else if (rd_reg.rvalid && s_axi_rready)
        begin
            rd_next.rvalid = 1'b0;
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rd_reg.rvalid <= `PBC_RST_BIT;
            rd_reg.data <= 8'h00;
            rd_reg.rresp <= `PBC_RESP_OKAY;
        end
        else if (ce)
        begin
            rd_reg <= rd_next;
        end
    end

    assign s_axi_rvalid = rd_reg.rvalid;
    assign s_axi_rresp = rd_reg.rresp;
    assign s_axi_rdata = {24'h000000, rd_reg.data};

    // Register file; hardware sets win over software clears
    always_comb
    begin
        regs_next = regs_reg;
        if (do_write && wr_reg.strb0)
        begin
            unique case (wr_sel)
                PBC_SEL_FLAGS:
                begin
                    // Writing zero clears; writing one leaves the flag alone
                    regs_next.flags = regs_reg.flags
                        & wr_reg.data[`PBC_PIN_MSB:`PBC_PIN_LSB];
                end
                PBC_SEL_RISE: regs_next.rise_en = wr_reg.data[`PBC_PIN_MSB:`PBC_PIN_LSB];
                PBC_SEL_FALL: regs_next.fall_en = wr_reg.data[`PBC_PIN_MSB:`PBC_PIN_LSB];
                PBC_SEL_ICTL: regs_next.irq_en = wr_reg.data[`PBC_ICTL_IE_BIT];
                PBC_SEL_MASK: regs_next.mask = wr_reg.data[`PBC_PIN_MSB:`PBC_PIN_LSB];
                PBC_SEL_STAT: regs_next.status = regs_reg.status;
                PBC_SEL_NONE: regs_next.status = regs_reg.status;
            endcase
        end
        // Status clears when read
        if (ar_take && rd_sel == PBC_SEL_STAT)
        begin
            regs_next.status = 4'h0;
        end
        // Hardware sets go last so an edge beats a clear in the same cycle
        regs_next.flags = regs_next.flags | edge_set;
        regs_next.status = regs_next.status | edge_set;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            regs_reg.flags <= `PBC_RST_PINS;
            regs_reg.rise_en <= `PBC_RST_PINS;
            regs_reg.fall_en <= `PBC_RST_PINS;
            regs_reg.irq_en <= `PBC_RST_BIT;
            regs_reg.status <= `PBC_RST_PINS;
            regs_reg.mask <= `PBC_RST_PINS;
        end
        else if (ce)
        begin
            regs_reg <= regs_next;
        end
    end

    // Global flag and interrupt request
    assign global_change_flag = |regs_reg.flags;
    // Two sources: the enabled global flag, or any unmasked status bit
    assign irq_from_flags = global_change_flag && regs_reg.irq_en;
    assign irq_from_status = |(regs_reg.status & regs_reg.mask);
    assign irq = irq_from_flags || irq_from_status;

endmodule : pbc_top

// ==== testbench/pbc_top_props.sv ====
// Purpose: Port-level checks for the pin-change block
// Assumes: ce held high by the bench
// Notes: Bound into pbc_top below
`timescale 1ns/1ps
`include "pbc_cfg.svh"
module pbc_top_props
(
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Pins
    input wire logic [3:0] portb_pin_x,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic [7:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    // Interrupt
    input wire logic global_change_flag,
    input wire logic irq
);
    logic [7:0] rd_addr_seen;
    // Address of the read in flight
    always_ff @(posedge aclk)
    begin
        if (s_axi_arvalid && s_axi_arready)
            rd_addr_seen <= s_axi_araddr;
    end
    default clocking @(posedge aclk); endclocking
    default disable iff (!aresetn);
    a_flag_from_edge: assert property ($rose(global_change_flag) |->
        $past(portb_pin_x, 3) != $past(portb_pin_x, 4)
        || $past(portb_pin_x, 4) != $past(portb_pin_x, 5))
        else $error("flag rose without a pin edge");
    a_flag_sticky: assert property ($fell(global_change_flag) |->
        $rose(s_axi_bvalid)) else $error("flag fell without a write");
    a_upper_zero: assert property (s_axi_rvalid && rd_addr_seen != `PBC_OFF_ICTL |->
        s_axi_rdata[31:8] == 24'h0 && s_axi_rdata[3:0] == 4'h0)
        else $error("unimplemented read bits set");
    a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
        && s_axi_wready |-> ##2 s_axi_bvalid) else $error("write not answered");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata)) else $error("read data dropped");
    a_bresp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp)) else $error("write response dropped");
    a_busy_refuses: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
        else $error("write taken while response pending");
    c_flag: cover property ($rose(global_change_flag));
    c_irq: cover property ($rose(irq));
    c_slverr: cover property (s_axi_bvalid && s_axi_bresp == 2'h2);
endmodule : pbc_top_props

bind pbc_top pbc_top_props u_props (.aclk, .aresetn, .portb_pin_x, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready,
    .s_axi_bresp, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
    .s_axi_rdata, .global_change_flag, .irq);

// ==== testbench/pbc_pin_model.sv ====
// Purpose: Drives the port pins to the levels the bench asks for
// Assumes: Pins are plain driven levels, no pull
// Notes: Level changes land just after a clock edge
`timescale 1ns/1ps
module pbc_pin_model
(
    // Clock
    input wire logic aclk,
    // Requested and driven levels
    input wire logic [3:0] want,
    output logic [3:0] pins
);
    initial pins = 4'h0;
    always @(posedge aclk)
        pins <= want;
endmodule : pbc_pin_model

// ==== testbench/test_portb_change_flag_logic.sv ====
// Purpose: Self-checking bench for the pin-change block
// Assumes: ce and wstrb held on
// Notes: Expected reads queued by the driver, checked by a monitor
`timescale 1ns/1ps
`include "pbc_cfg.svh"
`define CHK(g, w) begin n_checks++; if ((g) !== (w)) begin err_count++; \
    $display("unexpected at %0t: got %h want %h", $time, g, w); end end
module test_portb_change_flag_logic;
    logic aclk = 0, aresetn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [7:0] awaddr = 0, araddr = 0;
    logic [31:0] wdata = 0;
    logic [3:0] want = 0, pins;
    wire logic awready, wready, bvalid, arready, rvalid, gcf, irq;
    wire logic [1:0] bresp, rresp;
    wire logic [31:0] rdata;
    logic [1:0] qb[$];
    logic [33:0] qr[$];
    logic [1:0] exp_b;
    logic [33:0] exp_r;
    int err_count = 0, n_checks = 0, cyc = 0;
    initial forever #12.5 aclk = ~aclk;
    pbc_pin_model pin_u (.aclk, .want, .pins);
    pbc_top dut_u (.aclk, .aresetn, .ce(1'b1), .portb_pin_x(pins), .s_axi_awaddr(awaddr),
        .s_axi_awvalid(awv), .s_axi_awready(awready), .s_axi_wdata(wdata),
        .s_axi_wstrb(4'hf), .s_axi_wvalid(wv), .s_axi_wready(wready), .s_axi_bresp(bresp),
        .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
        .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .global_change_flag(gcf), .irq);
    always @(posedge aclk)
    begin
        cyc++;
        if (bvalid && bready)
        begin
            exp_b = qb.pop_front();
            `CHK(bresp, exp_b)
        end
        if (rvalid && rready)
        begin
            exp_r = qr.pop_front();
            `CHK({rresp, rdata}, exp_r)
        end
        if (cyc == 20000)
        begin
            err_count++;
            give_verdict();
        end
    end
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
        bit fa = 0;
        bit fw = 0;
        qb.push_back(r);
        @(posedge aclk);
        awaddr <= a;
        wdata <= {24'h0, d};
        awv <= 1;
        wv <= 1;
        while (!(fa && fw))
        begin
            @(negedge aclk);
            fa |= awready;
            fw |= wready;
            @(posedge aclk);
            if (fa) awv <= 0;
            if (fw) wv <= 0;
        end
        repeat ($urandom % 5) @(posedge aclk);
        bready <= 1;
        do @(negedge aclk); while (!bvalid);
        @(posedge aclk);
        bready <= 0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] d, input logic [1:0] r = 2'h0);
        qr.push_back({r, 24'h0, d});
        @(posedge aclk);
        araddr <= a;
        arv <= 1;
        do @(negedge aclk); while (!arready);
        @(posedge aclk);
        arv <= 0;
        repeat ($urandom % 5) @(posedge aclk);
        rready <= 1;
        do @(negedge aclk); while (!rvalid);
        @(posedge aclk);
        rready <= 0;
    endtask : rd
    task automatic pin(input logic [3:0] v);
        @(posedge aclk);
        want <= v;
        repeat (8) @(posedge aclk);
    endtask : pin
    task automatic outs(input logic g, input logic i);
        @(negedge aclk);
        `CHK(gcf, g)
        `CHK(irq, i)
    endtask : outs
    task automatic done(input string s);
        $display("test %s done", s);
    endtask : done
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", n_checks, err_count);
        if (err_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : give_verdict
    initial
    begin
        logic [7:0] r;
        logic [7:0] e;
        r = 8'($urandom(32'h764d466a));
        repeat (5) @(posedge aclk);
        aresetn <= 1;
        rd(`PBC_OFF_FLAGS, 8'h00);
        rd(`PBC_OFF_RISE, 8'h00);
        rd(`PBC_OFF_ICTL, 8'h00);
        rd(8'h18, 8'h00, 2'h2);
        wr(8'h18, 8'hff, 2'h2);
        done("reset");
        // Random rise enables, every pin rises
        r = 8'($urandom);
        e = (r | (~r & 8'h30)) & 8'hf0;
        wr(`PBC_OFF_RISE, r);
        rd(`PBC_OFF_RISE, r & 8'hf0);
        pin(4'hf);
        rd(`PBC_OFF_FLAGS, r & 8'hf0);
        outs(|r[7:4], 1'b0);
        done("rise");
        // Falls armed only on pins 5 and 4, where their rise enable is clear
        wr(`PBC_OFF_FALL, ~r & 8'h30);
        pin(4'h0);
        rd(`PBC_OFF_FLAGS, e);
        wr(`PBC_OFF_FLAGS, 8'h7f);
        rd(`PBC_OFF_FLAGS, e & 8'h70);
        wr(`PBC_OFF_FLAGS, 8'h00);
        rd(`PBC_OFF_FLAGS, 8'h00);
        outs(1'b0, 1'b0);
        done("clear");
        // Interrupt raised, cleared, unmasked through the status mask, cleared by a status read
        wr(`PBC_OFF_RISE, 8'h80);
        wr(`PBC_OFF_ICTL, 8'h08);
        pin(4'h8);
        rd(`PBC_OFF_ICTL, 8'h09);
        outs(1'b1, 1'b1);
        wr(`PBC_OFF_FLAGS, 8'h00);
        outs(1'b0, 1'b0);
        wr(`PBC_OFF_MASK, 8'hf0);
        outs(1'b0, 1'b1);
        rd(`PBC_OFF_STAT, e | 8'h80);
        outs(1'b0, 1'b0);
        done("irq");
        // Reset again with pin 7 high, rise enables written at once
        @(posedge aclk);
        aresetn <= 0;
        repeat (3) @(posedge aclk);
        fork
            wr(`PBC_OFF_RISE, 8'hf0);
            @(posedge aclk) aresetn <= 1;
        join
        rd(`PBC_OFF_RISE, 8'hf0);
        pin(4'h8);
        rd(`PBC_OFF_FLAGS, 8'h00);
        outs(1'b0, 1'b0);
        done("reset again");
        give_verdict();
    end
endmodule : test_portb_change_flag_logic
